// file: csb_channel.sv
/*
 * clocked serial bus channel: three-wire shift mode and two-wire
 * multi-drop bus slave mode, registers on classic wishbone.
 * assumes pins are asynchronous, external pull-ups on open-drain lines.
 */
// The Wishbone slave port was decided locally.
// What this block does
// - control register resets to zero, byte writable
// - release trigger sets output latch, self-clears
// - command trigger clears output latch, self-clears
// - triggers held clear while channel disabled
// - falling clock edge shifts bit onto output
// - rising clock edge captures input bit
// - stop after eight bits, set done flag
// - output pin push-pull in three-wire mode, mirrors output latch
// - internal clock idle level from port latch
// - mode bit 2 picks first bit order
// - order reversed on access, not shifting
// - data write starts only when enabled, ready
// - enabling after data write starts nothing
// - bus mode data line is open-drain
// - slave classifies bytes: address, command, data
// - wake-up: interrupt only on own address
// - slave detects data rise while clock high
// - slave detects data fall while clock high
// - command after release marks address byte
module csb_channel
    import csb_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_DEF
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // wishbone slave
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    // serial clock pin
    input  wire logic             serial_clock_pin_i,
    output logic                  serial_clock_pin_o,
    output logic                  serial_clock_pin_oe_n,
    // serial input pin
    input  wire logic             serial_input_pin_i,
    // serial output / bus data pin
    input  wire logic             bus_data_line_b_i,
    output logic                  bus_data_line_b_o,
    output logic                  bus_data_line_b_oe_n,
    // event
    output logic                  channel_interrupt
);
    csb_mode_type  mode_q;
    csb_state_type state_q;
    csb_byte_type  next_type_q;
    csb_byte_type  last_type_q;
    csb_edge_type  sck_ev;
    csb_edge_type  sd_ev;
    csb_edge_type  si_ev;
    logic [7:0]    ctrl_q;
    logic [7:0]    sr_q;
    logic [7:0]    saddr_q;
    logic [2:0]    bit_cnt_q;
    logic [$clog2(SCK_HALF+1)-1:0] div_q;
    logic          ack_q;
    logic          so_latch_q;
    logic          port_q;
    logic          sck_q;
    logic          done_q;
    logic          irq_q;
    logic          rel_pend_q;
    logic [15:0]   idx;
    logic          wr;
    logic          rd;
    logic [7:0]    wdat;
    logic          bus_mode;
    logic          int_clk;
    logic          tick;
    logic          fall_ev;
    logic          rise_ev;
    logic          in_bit;
    logic          can_start;
    logic          start;
    logic          rel_ev;
    logic          cmd_ev;
    logic          set_done;
    logic          wr_rel;
    logic          wr_cmd;

    // pin synchronisers
    csb_sync_edge u_sck (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_i   (serial_clock_pin_i),
        .ev      (sck_ev)
    );
    csb_sync_edge u_sd (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_i   (bus_data_line_b_i),
        .ev      (sd_ev)
    );
    csb_sync_edge u_si (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_i   (serial_input_pin_i),
        .ev      (si_ev)
    );

    // bus access decode; effect lands on the edge that raises ack
    assign idx  = wb_adr_i[ADR_W-1:2];
    assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
    assign rd   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
    assign wdat = wb_dat_i[7:0];

    assign bus_mode = mode_q.opmode[1];
    assign int_clk  = mode_q.clk_sel[1];
    assign tick     = (div_q == '0);

    // shift edges from internal divider or synchronised pin
    assign fall_ev = int_clk ? (tick & sck_q) : sck_ev.fall;
    assign rise_ev = int_clk ? (tick & ~sck_q) : sck_ev.rise;
    assign in_bit  = bus_mode ? sd_ev.lvl : si_ev.lvl;

    assign can_start = mode_q.enable & (state_q == ST_IDLE) &
                       (int_clk | sck_ev.lvl);
    assign start     = wr & (idx == IDX_SHIFT) & can_start;

    // bus events need the clock high before and after the data edge
    assign rel_ev = mode_q.enable & bus_mode & sck_ev.lvl &
                    ~sck_ev.rise & sd_ev.rise;
    assign cmd_ev = mode_q.enable & bus_mode & sck_ev.lvl &
                    ~sck_ev.rise & sd_ev.fall;

    assign wr_rel = wr & (idx == IDX_CTRL) & wdat[CTRL_REL_TRIG] &
                    mode_q.enable;
    assign wr_cmd = wr & (idx == IDX_CTRL) & wdat[CTRL_CMD_TRIG] &
                    mode_q.enable;

    // wake-up filters the done flag to own address only
    assign set_done = (state_q == ST_FIN) &
                      (~(mode_q.wake & bus_mode) |
                       ((next_type_q == BT_ADDR) &
                        (sr_q == saddr_q)));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q    <= wb_cyc_i & wb_stb_i & ~ack_q;
            wb_dat_o <= 32'h0000_0000;
            if (rd) begin
                if (idx == IDX_MODE) begin
                    wb_dat_o[7:0] <= mode_q;
                end else if (idx == IDX_CTRL) begin
                    wb_dat_o[7:0] <= ctrl_q;
                end else if (idx == IDX_SHIFT) begin
                    wb_dat_o[7:0] <= mode_q.lsb_first ?
                                     csb_rev8(sr_q) : sr_q;
                end else if (idx == IDX_STAT) begin
                    wb_dat_o[STAT_DONE] <= done_q;
                    wb_dat_o[STAT_BUSY] <= (state_q != ST_IDLE);
                    wb_dat_o[STAT_TYPE_LO+:2] <= last_type_q;
                    wb_dat_o[STAT_SCK]  <= sck_ev.lvl;
                    wb_dat_o[STAT_PORT] <= port_q;
                end else if (idx == IDX_SADDR) begin
                    wb_dat_o[7:0] <= saddr_q;
                end
            end
        end
    end
    assign wb_ack_o = ack_q;

    // software registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q  <= RST_MODE;
            saddr_q <= RST_SADDR;
            port_q  <= RST_PORT;
        end else if (wr) begin
            if (idx == IDX_MODE) begin
                mode_q <= wdat;
            end else if (idx == IDX_SADDR) begin
                saddr_q <= wdat;
            end else if (idx == IDX_STAT) begin
                port_q <= wdat[STAT_PORT];
            end
        end
    end

    // control register; triggers never stay set, seen bits set win
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= RST_CTRL;
        end else begin
            if (wr && idx == IDX_CTRL) begin
                ctrl_q[7:4] <= wdat[7:4];
                ctrl_q[CTRL_REL_SEEN] <= wdat[CTRL_REL_SEEN];
                ctrl_q[CTRL_CMD_SEEN] <= wdat[CTRL_CMD_SEEN];
            end
            ctrl_q[CTRL_REL_TRIG] <= 1'b0;
            ctrl_q[CTRL_CMD_TRIG] <= 1'b0;
            if (rel_ev) begin
                ctrl_q[CTRL_REL_SEEN] <= 1'b1;
            end
            if (cmd_ev) begin
                ctrl_q[CTRL_CMD_SEEN] <= 1'b1;
            end
        end
    end

    // output latch: shifting wins over triggers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            so_latch_q <= RST_SO;
        end else if (state_q == ST_RUN && fall_ev) begin
            so_latch_q <= sr_q[7];
        end else if (wr_rel) begin
            so_latch_q <= 1'b1;
        end else if (wr_cmd) begin
            so_latch_q <= 1'b0;
        end
    end

    // transfer sequencing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 3'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    bit_cnt_q <= 3'h0;
                    if (start) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!mode_q.enable) begin
                        state_q <= ST_IDLE;
                    end else if (rise_ev) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == LAST_BIT) begin
                            state_q <= ST_FIN;
                        end
                    end
                end
                ST_FIN: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // shift register; order swap only on access
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sr_q <= RST_SHIFT;
        end else if (wr && idx == IDX_SHIFT && state_q == ST_IDLE) begin
            sr_q <= mode_q.lsb_first ? csb_rev8(wdat) : wdat;
        end else if (state_q == ST_RUN && rise_ev) begin
            sr_q <= {sr_q[6:0], in_bit};
        end
    end

    // internal clock divider and generated serial clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
            sck_q <= RST_PORT;
        end else if (state_q == ST_RUN && int_clk) begin
            div_q <= tick ? ($bits(div_q))'(SCK_HALF - 1)
                          : div_q - ($bits(div_q))'(1);
            if (tick) begin
                sck_q <= ~sck_q;
            end
        end else begin
            div_q <= ($bits(div_q))'(SCK_HALF - 1);
            sck_q <= port_q;
        end
    end

    // pin drivers
    assign serial_clock_pin_o    = sck_q;
    assign serial_clock_pin_oe_n = ~int_clk;
    assign bus_data_line_b_o     = bus_mode ? 1'b0 : so_latch_q;
    assign bus_data_line_b_oe_n  = bus_mode ? so_latch_q : 1'b0;

    // byte classification from release and command events
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rel_pend_q  <= 1'b0;
            next_type_q <= BT_DATA;
            last_type_q <= BT_DATA;
        end else begin
            if (rel_ev) begin
                rel_pend_q <= 1'b1;
            end else if (cmd_ev || state_q == ST_FIN) begin
                rel_pend_q <= 1'b0;
            end
            if (cmd_ev) begin
                next_type_q <= rel_pend_q ? BT_ADDR : BT_CMD;
            end else if (state_q == ST_FIN) begin
                next_type_q <= BT_DATA;
                last_type_q <= next_type_q;
            end
        end
    end

    // done flag: write one clears, hardware set wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            irq_q <= set_done;
            if (set_done) begin
                done_q <= 1'b1;
            end else if (wr && idx == IDX_STAT && wdat[STAT_DONE]) begin
                done_q <= 1'b0;
            end
        end
    end
    assign channel_interrupt = irq_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_rel_trig;
        wr_rel && !(state_q == ST_RUN && fall_ev) |=> so_latch_q;
    endproperty
    a_rel_trig: assert property (p_rel_trig)
        else $error("release trigger did not set latch");

    property p_cmd_trig;
        wr_cmd && !wr_rel && !(state_q == ST_RUN && fall_ev)
            |=> !so_latch_q;
    endproperty
    a_cmd_trig: assert property (p_cmd_trig)
        else $error("command trigger did not clear latch");

    property p_trig_off;
        wr && idx == IDX_CTRL && !mode_q.enable && state_q == ST_IDLE
            |=> $stable(so_latch_q) && ctrl_q[1:0] == 2'h0;
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("trigger acted while disabled");

    property p_shift_out;
        state_q == ST_RUN && fall_ev |=> so_latch_q == $past(sr_q[7]);
    endproperty
    a_shift_out: assert property (p_shift_out)
        else $error("falling edge did not drive msb");

    property p_capture;
        state_q == ST_RUN && rise_ev |=> sr_q[0] == $past(in_bit);
    endproperty
    a_capture: assert property (p_capture)
        else $error("rising edge did not capture input");

    property p_eight;
        state_q == ST_RUN && mode_q.enable && rise_ev &&
            bit_cnt_q == 3'h7 |=> state_q == ST_FIN ##1 state_q == ST_IDLE;
    endproperty
    a_eight: assert property (p_eight)
        else $error("transfer did not end after eight bits");

    property p_pushpull;
        !bus_mode |-> !bus_data_line_b_oe_n &&
            bus_data_line_b_o == so_latch_q;
    endproperty
    a_pushpull: assert property (p_pushpull)
        else $error("output pin not following latch");

    property p_start;
        start |=> state_q == ST_RUN;
    endproperty
    a_start: assert property (p_start)
        else $error("transfer did not start");

    property p_no_start;
        wr && idx == IDX_SHIFT && !mode_q.enable && state_q == ST_IDLE
            |=> state_q == ST_IDLE;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("transfer started while disabled");

    property p_open_drain;
        bus_mode |-> !bus_data_line_b_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("bus line driven high");

    property p_rel_seen;
        rel_ev |=> ctrl_q[CTRL_REL_SEEN] && rel_pend_q;
    endproperty
    a_rel_seen: assert property (p_rel_seen)
        else $error("release not recorded");

    property p_addr;
        rel_pend_q && cmd_ev |=> next_type_q == BT_ADDR;
    endproperty
    a_addr: assert property (p_addr)
        else $error("address byte not marked");

    c_xfer: cover property (state_q == ST_FIN ##1 channel_interrupt);
    c_cmd:  cover property (cmd_ev);
    c_wake: cover property (mode_q.wake && state_q == ST_FIN &&
                            set_done);
endmodule

// file: csb_pkg.sv
/*
 * shared constants, types and helpers of the clocked serial bus channel.
 * assumes a 32-bit classic wishbone register bus and one 25 MHz clock.
 */
package csb_pkg;
    // register indices; byte address is four times the index
    localparam int          ADR_W     = 18;
    localparam logic [15:0] IDX_MODE  = 16'hff60;
    localparam logic [15:0] IDX_CTRL  = 16'hff61;
    localparam logic [15:0] IDX_SHIFT = 16'hff62;
    localparam logic [15:0] IDX_STAT  = 16'hff63;
    localparam logic [15:0] IDX_SADDR = 16'hff64;

    // reset values
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_SADDR = 8'h00;
    localparam logic [7:0] RST_SHIFT = 8'h00;
    localparam logic       RST_PORT  = 1'b1;
    localparam logic       RST_SO    = 1'b1;

    // control register fields
    localparam int CTRL_REL_TRIG = 0;
    localparam int CTRL_CMD_TRIG = 1;
    localparam int CTRL_REL_SEEN = 2;
    localparam int CTRL_CMD_SEEN = 3;

    // status register fields
    localparam int STAT_DONE    = 0;
    localparam int STAT_BUSY    = 1;
    localparam int STAT_TYPE_LO = 2;
    localparam int STAT_SCK     = 4;
    localparam int STAT_PORT    = 7;

    // timing: index of the last bit of a unit, half period of internal clock in cycles
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam int         SCK_HALF_DEF = 4;

    typedef struct packed {
        logic       enable;
        logic       rsv;
        logic       wake;
        logic [1:0] opmode;
        logic       lsb_first;
        logic [1:0] clk_sel;
    } csb_mode_type;

    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } csb_edge_type;

    typedef enum logic [1:0] {
        BT_DATA = 2'h0,
        BT_ADDR = 2'h1,
        BT_CMD  = 2'h2
    } csb_byte_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_FIN  = 3'h4
    } csb_state_type;

    function automatic logic [7:0] csb_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction
endpackage

// file: csb_sync_edge.sv
/*
 * two-flop synchroniser with edge detection for one pin.
 * assumes the pin is asynchronous to clk.
 */
module csb_sync_edge
    import csb_pkg::*;
(
    // clock and reset
    input  wire logic    clk,
    input  wire logic    sys_rst,
    // pin and result
    input  wire logic    pin_i,
    output csb_edge_type ev
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign ev.lvl  = s2_q;
    assign ev.rise = s2_q & ~s3_q;
    assign ev.fall = ~s2_q & s3_q;
endmodule

// file: csb_peer.sv
/*
 * far-side peer: three-wire slave and two-wire bus master.
 * assumes the bench resolves the clock and data lines.
 */
module csb_peer (
    // line levels
    input  wire logic sck_i,
    input  wire logic sd_i,
    // drives, high is released
    output logic      sck_o,
    output logic      sd_o,
    output logic      si_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx;
    logic [7:0] rx;
    int         n = 8;
    int         lag = 0;
    initial begin
        {sck_o, sd_o, si_o} = 3'h7;
    end
    task automatic load(input logic [7:0] b, input int l);
        tx = b;
        lag = l;
        n = 0;
    endtask
    // slave answers after falling, samples on rising
    always @(negedge sck_i) begin
        if (n < 8) begin
            #(lag) si_o = tx[7-n];
        end
        n++;
    end
    always @(posedge sck_i) begin
        rx = {rx[6:0], sd_i};
        // unit over: no stale level on the line
        if (n >= 8) begin
            si_o = ~si_o;
        end
    end
    task automatic ev(input bit bus_release_event, input bit cmd);
        #7;
        if (bus_release_event) begin
            sck_o = 1'b0;
            #160 sd_o = 1'b0;
            #160 sck_o = 1'b1;
            #160 sd_o = 1'b1;
            #320;
        end
        if (cmd) begin
            if (!sd_o) begin
                sck_o = 1'b0;
                #160 sd_o = 1'b1;
                #160 sck_o = 1'b1;
                #160;
            end
            sd_o = 1'b0;
            #320;
        end
    endtask
    // data moves only while the clock is low
    task automatic put(input logic [7:0] b);
        #7;
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            #80 sd_o = b[i];
            #80 sck_o = 1'b1;
            #160;
        end
    endtask
endmodule

// file: tb.sv
/*
 * self-checking bench of the serial bus channel.
 * assumes the peer model and pulled-up clock and data lines.
 */
module tb
    import csb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0]      dat = 32'h0;
    logic [3:0]       sel = 4'h0;
    logic             we = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic [31:0]      dat_o;
    logic             ack;
    logic             sck_o, sck_oe_n, sd_o, sd_oe_n, irq;
    wire logic        sck_w, sd_w, p_sck, p_sd, p_si;
    int               num_errors = 0;
    int               num_checks = 0;
    logic [2:0]       fr [6] = '{3'h6, 3'h2, 3'h0, 3'h7, 3'h7, 3'h3};
    always #20 clk = ~clk;
    assign sck_w = (sck_oe_n | sck_o) & p_sck;
    assign sd_w = (sd_oe_n | sd_o) & p_sd;
    csb_channel #(.SCK_HALF(4)) u_csb_channel (
        .clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .serial_clock_pin_i(sck_w),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .serial_input_pin_i(p_si), .bus_data_line_b_i(sd_w),
        .bus_data_line_b_o(sd_o), .bus_data_line_b_oe_n(sd_oe_n),
        .channel_interrupt(irq));
    csb_peer u_csb_peer (.sck_i(sck_w), .sd_i(sd_w), .sck_o(p_sck),
        .sd_o(p_sd), .si_o(p_si));
    function automatic logic [7:0] rev(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction
    function automatic logic [1:0] btype(input bit bus_release_event, input bit cmd);
        return cmd ? (bus_release_event ? BT_ADDR : BT_CMD) : BT_DATA;
    endfunction
    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic wb(input bit w, input logic [15:0] ix,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        dat <= {24'h0, d};
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [15:0] ix, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, ix, d, 4'h1, q);
    endtask
    task automatic rd(input logic [15:0] ix, output logic [7:0] q);
        wb(1'b0, ix, 8'h00, 4'hf, q);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic wirq(input bit exp);
        bit hit;
        hit = 1'b0;
        for (int n = 0; n < 300 && !hit; n++) begin
            @(posedge clk);
            hit = (irq === 1'b1);
        end
        check("irq", 8'(exp), 8'(hit));
        if (exp && !hit) begin
            end_sim();
        end
    endtask
    initial begin
        logic [7:0] q, tx, rb;
        bit         lsb, rl, cm, wk, ex;
        void'($urandom(81));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(IDX_CTRL, q);
        check("ctrl_rst", 8'h00, q);
        wb(1'b1, IDX_CTRL, 8'hf0, 4'h0, q);
        rd(IDX_CTRL, q);
        check("ctrl_nosel", 8'h00, q);
        wr(IDX_CTRL, 8'hf0);
        rd(IDX_CTRL, q);
        check("ctrl_byte", 8'hf0, q);
        wr(16'hff70, 8'h55);
        rd(16'hff70, q);
        check("unmapped", 8'h00, q);
        wr(IDX_CTRL, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(IDX_MODE, m ? 8'h10 : 8'h00);
            wr(IDX_CTRL, 8'h02);
            settle();
            check("trig_off", 8'h01, 8'(sd_w));
            rd(IDX_CTRL, q);
            check("trig_off_rd", 8'h00, q & 8'h03);
            wr(IDX_MODE, m ? 8'h90 : 8'h80);
            for (int t = 1; t >= 0; t--) begin
                wr(IDX_CTRL, 8'(1 << t));
                settle();
                q = t ? 8'h00 : (m ? 8'h01 : 8'h02);
                check("trig_pin", q, {6'h0, sd_o, sd_oe_n});
                rd(IDX_CTRL, q);
                check("trig_clr", 8'h00, q & 8'h03);
            end
        end
        wr(IDX_MODE, 8'h82);
        wr(IDX_STAT, 8'h00);
        settle();
        check("sck_idle0", 8'h00, 8'(sck_w));
        wr(IDX_STAT, 8'h80);
        settle();
        check("sck_idle1", 8'h01, 8'(sck_w));
        wr(IDX_MODE, 8'h02);
        wr(IDX_SHIFT, 8'h3c);
        wr(IDX_MODE, 8'h82);
        wirq(1'b0);
        rd(IDX_STAT, q);
        check("no_busy", 8'h00, 8'(q[STAT_BUSY]));
        // wake kept 0 and triggers left alone here
        for (int i = 0; i < 10; i++) begin
            lsb = i < 2 ? i[0] : 1'($urandom);
            tx = i < 2 ? 8'h01 : 8'($urandom);
            rb = i < 2 ? 8'h80 : 8'($urandom);
            wr(IDX_MODE, {5'h10, lsb, 2'h2});
            u_csb_peer.load(rb, 20 * int'($urandom % 2));
            wr(IDX_SHIFT, tx);
            wr(IDX_SHIFT, ~tx);
            wirq(1'b1);
            check("wire", lsb ? rev(tx) : tx, u_csb_peer.rx);
            rd(IDX_SHIFT, q);
            check("rx", lsb ? rev(rb) : rb, q);
            rd(IDX_STAT, q);
            check("done", 8'h01, 8'(q[STAT_DONE]));
            wr(IDX_STAT, 8'h81);
        end
        // release the latch while still in three-wire mode, so that
        // bus mode starts with the data line let go
        wr(IDX_CTRL, 8'h01);
        wr(IDX_SADDR, 8'h5a);
        for (int k = 0; k < 6; k++) begin
            {rl, cm, wk} = fr[k];
            tx = wk ? (k == 3 ? 8'ha5 : 8'h5a) : 8'($urandom);
            ex = !wk || (rl && cm && tx == 8'h5a);
            wr(IDX_MODE, wk ? 8'hb0 : 8'h90);
            wr(IDX_CTRL, 8'h00);
            u_csb_peer.ev(rl, cm);
            rd(IDX_CTRL, q);
            check("seen", 8'({cm, rl}), 8'(q[3:2]));
            wr(IDX_SHIFT, 8'hff);
            fork
                u_csb_peer.put(tx);
                wirq(ex);
            join
            rd(IDX_STAT, q);
            check("type", 8'(btype(rl, cm)), 8'(q[3:2]));
            check("bus_done", 8'(ex), 8'(q[STAT_DONE]));
            if (!wk) begin
                rd(IDX_SHIFT, q);
                check("bus_rx", tx, q);
            end
            wr(IDX_STAT, 8'h81);
        end
        end_sim();
    end
endmodule
